// >>> rtl/urhd_apb_slave.sv
// Purpose: APB slave front end with one wait state
// Assumes: Master holds the request until pready
// Notes:   Writes land on the completing edge only
module urhd_apb_slave
    import urhd_pkg::*;
(
    input  logic        pclk,
    input  logic        presetn,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [11:0] paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    urhd_bus_if.slave   bus
);
    typedef struct packed {
        logic        ready;
        logic        err;
        logic [31:0] rdata;
    } urhd_apb_st_t;

    urhd_apb_st_t st_q;
    urhd_apb_st_t st_d;
    logic         first_acc;

    // First access cycle samples the map; the second completes
    assign first_acc = psel & penable & ~st_q.ready;
    assign bus.addr  = paddr;
    assign bus.wdata = pwdata;
    assign bus.wr_go = psel & penable & st_q.ready & pwrite & bus.hit;

    // Read data captured a cycle early so prdata leaves a flop
    always_comb
    begin
        st_d       = st_q;
        st_d.ready = first_acc;
        st_d.err   = first_acc & ~bus.hit;
        if (first_acc)
        begin
            st_d.rdata = (pwrite | ~bus.hit) ? 32'h0000_0000 : bus.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign prdata  = st_q.rdata;
    assign pready  = st_q.ready;
    assign pslverr = st_q.err;

    // Each answer lasts exactly one cycle
    a_ready_single : assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held longer than one cycle");
endmodule

// >>> rtl/urhd_ifs.sv
// Purpose: Carriers between the descriptor block and its helpers
// Assumes: All signals on pclk
// Notes:   Bus carrier is driven by the APB slave, answered by the top
interface urhd_bus_if;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr_go;
    logic [31:0] rdata;
    logic        hit;
    modport slave (output addr, output wdata, output wr_go, input rdata, input hit);
    modport regs  (input addr, input wdata, input wr_go, output rdata, output hit);
endinterface

interface urhd_pwr_if;
    logic [1:0] psd;
    logic       always_pwr;
    logic       sw_scope;
    logic [3:1] mask;
    logic [3:1] en;
    logic       gon;
    logic       goff;
    logic [3:1] pon;
    logic [3:1] poff;
    logic       usb_rst;
    logic [3:1] port_power;
    logic       power_good;
    modport ctrl (output psd, output always_pwr, output sw_scope, output mask, output en,
                  output gon, output goff, output pon, output poff, output usb_rst,
                  input port_power, input power_good);
    modport pwr  (input psd, input always_pwr, input sw_scope, input mask, input en,
                  input gon, input goff, input pon, input poff, input usb_rst,
                  output port_power, output power_good);
endinterface

// >>> rtl/urhd_pkg.sv
// Purpose: Shared constants and types for the root hub descriptor block
// Assumes: 32-bit APB, pclk at 20 MHz
// Notes:   Offsets are byte addresses of aligned words
package urhd_pkg;
    // Register map
    localparam logic [11:0] OFF_DESC_A    = 12'h048;
    localparam logic [11:0] OFF_DESC_B    = 12'h04c;
    localparam logic [11:0] OFF_RH_STATUS = 12'h050;
    localparam logic [11:0] OFF_PORT_CMD  = 12'h060;
    // Descriptor A field positions
    localparam int DA_PSD_LSB    = 24;
    localparam int DA_OC_DIS     = 12;
    localparam int DA_OC_SCOPE   = 11;
    localparam int DA_COMPOUND   = 10;
    localparam int DA_ALWAYS_PWR = 9;
    localparam int DA_SW_SCOPE   = 8;
    // Descriptor B, hub status and port command positions
    localparam int DB_MASK_LSB   = 16;
    localparam int RS_GPWR_OFF   = 0;
    localparam int RS_OC_IND     = 1;
    localparam int RS_GPWR_ON    = 16;
    localparam int PC_ON_LSB     = 1;
    localparam int PC_OFF_LSB    = 9;
    // Reset values and port counts
    localparam logic [1:0] PSD_RST = 2'h1;
    localparam logic [7:0] PORTS_3 = 8'h03;
    localparam logic [7:0] PORTS_2 = 8'h02;
    localparam int         NPORT   = 3;
    // Settle timing: one delay unit is 2 ms
    localparam int PSD_UNIT_NS   = 2000000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PSD_UNIT_CYC  = PSD_UNIT_NS / CLK_PERIOD_NS;
    localparam int SETTLE_W      = 18;
    // Port power settle states
    typedef enum logic [2:0] {
        PS_OFF    = 3'b001,
        PS_SETTLE = 3'b010,
        PS_GOOD   = 3'b100
    } urhd_pstate_t;
endpackage

// >>> rtl/urhd_port_power.sv
// Purpose: Port power switch control with settle timer
// Assumes: Command pulses last one cycle
// Notes:   power_good waits the programmed settle delay after any port turns on
module urhd_port_power
    import urhd_pkg::*;
#(
    parameter int unsigned UNIT_CYC = PSD_UNIT_CYC
)
(
    input  logic      pclk,
    input  logic      presetn,
    urhd_pwr_if.pwr   p
);
    typedef struct packed {
        urhd_pstate_t          ps;
        logic [3:1]            pwr;
        logic [SETTLE_W-1:0]   cnt;
        logic                  good;
    } urhd_pp_st_t;

    urhd_pp_st_t st_q;
    urhd_pp_st_t st_d;
    logic        rise;

    // Settle length in cycles for a delay code
    function automatic logic [SETTLE_W-1:0] settle_load(input logic [1:0] code);
        settle_load = SETTLE_W'(int'(code) * int'(UNIT_CYC));
    endfunction

    // Port switch update, then settle sequencing
    always_comb
    begin
        st_d = st_q;
        rise = 1'b0;
        for (int i = 1; i <= NPORT; i++)
        begin
            if (p.always_pwr)
                st_d.pwr[i] = 1'b1;                         // [R09]
            else if (p.sw_scope && p.mask[i])
            begin
                if (p.pon[i])                               // [R12]
                    st_d.pwr[i] = 1'b1;
                else if (p.poff[i])
                    st_d.pwr[i] = 1'b0;
            end
            else
            begin
                if (p.gon)                                  // [R13] [R10]
                    st_d.pwr[i] = 1'b1;
                else if (p.goff)
                    st_d.pwr[i] = 1'b0;
            end
        end
        // Hub reset drops switched power, never the always-on case
        if (p.usb_rst && !p.always_pwr)
            st_d.pwr = 3'h0;
        st_d.pwr = st_d.pwr & p.en;
        rise     = |(st_d.pwr & ~st_q.pwr);
        case (st_q.ps)
            PS_OFF:
            begin
                if (rise)
                begin
                    st_d.ps  = PS_SETTLE;
                    st_d.cnt = settle_load(p.psd);          // [R03]
                end
            end
            PS_SETTLE:
            begin
                if (st_d.pwr == 3'h0)
                    st_d.ps = PS_OFF;
                else if (rise)
                    st_d.cnt = settle_load(p.psd);
                else if (st_q.cnt == '0)
                    st_d.ps = PS_GOOD;
                else
                    st_d.cnt = st_q.cnt - 1'b1;
            end
            PS_GOOD:
            begin
                if (st_d.pwr == 3'h0)
                    st_d.ps = PS_OFF;
                else if (rise)
                begin
                    st_d.ps  = PS_SETTLE;
                    st_d.cnt = settle_load(p.psd);
                end
            end
            default:
                st_d.ps = PS_OFF;
        endcase
        st_d.good = (st_d.ps == PS_GOOD);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= '{ps: PS_OFF, default: '0};
        else
            st_q <= st_d;
    end

    assign p.port_power = st_q.pwr;
    assign p.power_good = st_q.good;
endmodule

// >>> rtl/urhd_top.sv
// Purpose: Root hub descriptor registers and port power control
// Assumes: APB master per AMBA, inputs synchronous to pclk
// Notes:   Descriptors clear on presetn only; hub reset leaves them alone
//
// Design decision made here: the APB register port.

// What this block and its software do
// R01: Descriptors reset only by hardware reset
// R02: Software programs descriptors once at init
// R03: Settle delay byte, 2 ms units, default 01h
// R04: Only delay bits 25:24 stored, rest zero
// R05: Software writes nonzero settle delay
// R06: Bit 12 set disables over-current reporting
// R07: Over-current scope bit, global reporting only
// R08: Compound device bit reads zero always
// R09: Bit 9 set keeps ports always powered
// R10: Switching scope bit, global unless per-port
// R11: Port count 3 or 2 by enable
// R12: Mask bit selects per-port power commands
// R13: Status bit 16 write issues global on
// R14: Reserved and unused bits read zero
module urhd_top
    import urhd_pkg::*;
#(
    parameter int unsigned PSD_UNIT_CYCLES = PSD_UNIT_CYC
)
(
    input  logic        pclk,
    input  logic        presetn,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [11:0] paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  logic        third_port_en,
    input  logic        usb_state_reset,
    input  logic [3:1]  oc_sense,
    output logic [3:1]  port_power,
    output logic        power_good,
    output logic        overcurrent_alert
);
    typedef struct packed {
        logic [1:0] psd;
        logic       oc_dis;
        logic       oc_scope;
        logic       always_pwr;
        logic       sw_scope;
        logic [3:1] mask;
        logic       oc_alert;
    } urhd_desc_st_t;

    localparam urhd_desc_st_t DESC_RST = '{psd: PSD_RST, default: '0};

    urhd_bus_if    bus ();
    urhd_pwr_if    pw ();
    urhd_desc_st_t st_q;
    urhd_desc_st_t st_d;
    logic          wr_a;
    logic          wr_b;
    logic          wr_rs;
    logic          wr_pc;
    logic [31:0]   rd;
    logic          hit;
    logic [1:0]    psd_wr;

    // Downstream port count follows the third-port enable
    function automatic logic [7:0] port_count(input logic third);
        port_count = third ? PORTS_3 : PORTS_2;
    endfunction

    // Ports that exist for a given enable
    function automatic logic [3:1] en_mask(input logic third);
        en_mask = third ? 3'h7 : 3'h3;
    endfunction

    // Completing write to one register
    function automatic logic wr_at(input logic go, input logic [11:0] a,
                                   input logic [11:0] off);
        wr_at = go & (a == off);
    endfunction

    urhd_apb_slave u_apb
    (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus)
    );

    urhd_port_power #(
        .UNIT_CYC (PSD_UNIT_CYCLES)
    ) u_pwr
    (
        .pclk    (pclk),
        .presetn (presetn),
        .p       (pw)
    );

    // Write strobes per register
    assign wr_a   = wr_at(bus.wr_go, bus.addr, OFF_DESC_A);
    assign wr_b   = wr_at(bus.wr_go, bus.addr, OFF_DESC_B);
    assign wr_rs  = wr_at(bus.wr_go, bus.addr, OFF_RH_STATUS);
    assign wr_pc  = wr_at(bus.wr_go, bus.addr, OFF_PORT_CMD);
    assign psd_wr = bus.wdata[DA_PSD_LSB +: 2];

    // Commands are write-one pulses; zeros do nothing
    assign pw.gon  = wr_rs & bus.wdata[RS_GPWR_ON];                  // [R13]
    assign pw.goff = wr_rs & bus.wdata[RS_GPWR_OFF];
    assign pw.pon  = wr_pc ? bus.wdata[PC_ON_LSB +: NPORT] : 3'h0;
    assign pw.poff = wr_pc ? bus.wdata[PC_OFF_LSB +: NPORT] : 3'h0;

    // Configuration handed to the power switch control
    assign pw.psd        = st_q.psd;
    assign pw.always_pwr = st_q.always_pwr;
    assign pw.sw_scope   = st_q.sw_scope;
    assign pw.mask       = st_q.mask;
    assign pw.en         = en_mask(third_port_en);
    assign pw.usb_rst    = usb_state_reset;

    // Register updates; hub-state reset deliberately not used here
    always_comb
    begin
        st_d = st_q;
        if (wr_a)
        begin
            st_d.psd        = psd_wr;                                // [R04] [R01]
            st_d.oc_dis     = bus.wdata[DA_OC_DIS];                  // [R06]
            st_d.oc_scope   = bus.wdata[DA_OC_SCOPE];                // [R07]
            st_d.always_pwr = bus.wdata[DA_ALWAYS_PWR];              // [R09]
            st_d.sw_scope   = bus.wdata[DA_SW_SCOPE];                // [R10]
        end
        if (wr_b)
            st_d.mask = bus.wdata[DB_MASK_LSB + 1 +: NPORT];         // [R12]
        // Scope bit is stored only; reporting is always global
        st_d.oc_alert = ~st_q.oc_dis & |(oc_sense & en_mask(third_port_en)); // [R07]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= DESC_RST;                                        // [R01]
        else
            st_q <= st_d;
    end

    // Read mux; anything not listed answers with an error
    always_comb
    begin
        rd  = 32'h0000_0000;                                         // [R14]
        hit = 1'b1;
        case (bus.addr)
            OFF_DESC_A:
            begin
                rd[DA_PSD_LSB +: 2]  = st_q.psd;                     // [R03] [R04]
                rd[DA_OC_DIS]        = st_q.oc_dis;
                rd[DA_OC_SCOPE]      = st_q.oc_scope;
                rd[DA_COMPOUND]      = 1'b0;                         // [R08]
                rd[DA_ALWAYS_PWR]    = st_q.always_pwr;
                rd[DA_SW_SCOPE]      = st_q.sw_scope;
                rd[7:0]              = port_count(third_port_en);    // [R11]
            end
            OFF_DESC_B:
                rd[DB_MASK_LSB + 1 +: NPORT] = st_q.mask;
            OFF_RH_STATUS:
                rd[RS_OC_IND] = st_q.oc_alert;
            OFF_PORT_CMD:
                rd[PC_ON_LSB +: NPORT] = pw.port_power;
            default:
                hit = 1'b0;
        endcase
    end

    assign bus.rdata = rd;
    assign bus.hit   = hit;

    // Outputs leave flops directly
    assign port_power        = pw.port_power;
    assign power_good        = pw.power_good;
    assign overcurrent_alert = st_q.oc_alert;

    // Checks on the register bank and power behaviour
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_desc_hold_hubrst : assert property ( // [R01]
        usb_state_reset && !wr_a && !wr_b |=>
            $stable(st_q.psd) && $stable(st_q.always_pwr) && $stable(st_q.mask))
        else $error("hub reset disturbed descriptor contents");

    a_psd_store : assert property ( // [R03]
        wr_a |=> st_q.psd == $past(psd_wr))
        else $error("settle delay not stored from write");

    a_psd_upper_zero : assert property ( // [R04]
        pready && !pwrite && !pslverr && $past(paddr) == OFF_DESC_A |->
            prdata[31:26] == 6'h00)
        else $error("upper settle delay bits read nonzero");

    a_oc_disabled : assert property ( // [R06]
        st_q.oc_dis ##1 st_q.oc_dis |-> !overcurrent_alert)
        else $error("over-current reported while disabled");

    a_oc_global : assert property ( // [R07]
        !st_q.oc_dis && (|(oc_sense & en_mask(third_port_en))) |=> overcurrent_alert)
        else $error("over-current not reported");

    a_compound_zero : assert property ( // [R08]
        pready && !pwrite && $past(paddr) == OFF_DESC_A |-> !prdata[DA_COMPOUND])
        else $error("compound device bit read as one");

    a_always_powered : assert property ( // [R09]
        st_q.always_pwr |=> port_power == en_mask($past(third_port_en)))
        else $error("ports not powered in always-on mode");

    a_port_cmd_ignored : assert property ( // [R10]
        !st_q.sw_scope && !st_q.always_pwr && pw.pon[1] && !pw.gon &&
        !port_power[1] |=> !port_power[1])
        else $error("port command obeyed in global mode");

    a_port_count : assert property ( // [R11]
        pready && !pwrite && !pslverr && $past(paddr) == OFF_DESC_A |->
            prdata[7:0] == port_count($past(third_port_en)))
        else $error("downstream port count wrong");

    a_mask_gates_global : assert property ( // [R12]
        !st_q.always_pwr && st_q.sw_scope && st_q.mask[2] && !port_power[2] &&
        pw.gon && !pw.pon[2] |=> !port_power[2])
        else $error("masked port obeyed global command");

    a_global_on : assert property ( // [R13]
        pw.gon && !st_q.always_pwr && !st_q.sw_scope && !usb_state_reset |=>
            port_power[1] && port_power[2])
        else $error("global power on not applied");

    a_resv_zero : assert property ( // [R14]
        pready && !pwrite && $past(paddr) == OFF_DESC_B |->
            prdata[31:20] == 12'h000 && !prdata[DB_MASK_LSB] && prdata[15:0] == 16'h0000)
        else $error("reserved descriptor bits read nonzero");

    a_good_after_settle : assert property ( // [R03]
        $rose(|port_power) |-> !power_good)
        else $error("power good before settle time");

    // Main scenarios
    c_global_on : cover property (pw.gon ##1 (|port_power));

    c_per_port_on : cover property (st_q.sw_scope && (|(pw.pon & st_q.mask)) ##1 (|port_power));

    c_settle_done : cover property ($rose(power_good));

    c_oc_alert : cover property ($rose(overcurrent_alert));
endmodule

// >>> tb/urhd_sw_model.sv
// Purpose: Model of the external port power switches and sense lines
// Assumes: One over-current sense line per port, pulled low by the board
// Notes:   A fault shows only on a powered port, and only when the bench asks
module urhd_sw_model
(
    input  wire logic [3:1] port_power,
    input  wire logic [3:1] fault,
    output wire logic [3:1] oc_sense
);
    timeunit 1ns;
    timeprecision 1ps;

    // Unpowered switch cannot trip, so its pulled-down sense line reads low
    assign oc_sense = port_power & fault;
endmodule

// >>> tb/usb_root_hub_descriptor_regs_tb.sv
// Purpose: Self-checking bench for the root hub descriptor block
// Assumes: Settle unit shortened to 8 cycles; one wait state per access
// Notes:   Expected values come from the register layout, not from the design
module usb_root_hub_descriptor_regs_tb
    import urhd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned UNIT = 8;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        third_port_en;
    logic        usb_state_reset;
    logic [3:1]  oc_sense;
    logic [3:1]  port_power;
    logic        power_good;
    logic        overcurrent_alert;
    logic [3:1]  fault;
    logic [31:0] rd;
    logic        er;
    int          n_fail = 0;
    int          checked = 0;
    int          cyc = 0;

    urhd_top #(.PSD_UNIT_CYCLES(UNIT)) u_dut
    (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .third_port_en     (third_port_en),
        .usb_state_reset   (usb_state_reset),
        .oc_sense          (oc_sense),
        .port_power        (port_power),
        .power_good        (power_good),
        .overcurrent_alert (overcurrent_alert)
    );

    urhd_sw_model u_sw
    (
        .port_power (port_power),
        .fault      (fault),
        .oc_sense   (oc_sense)
    );

    // Clock at 20 MHz
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_fail++;
            $display("BAD t=%0t run timed out", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer; idle edge first so psel never toggles twice in a step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the bench timeout ends a stuck wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask

    task automatic hw_reset();
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        third_port_en = 1'b0;
        usb_state_reset = 1'b0;
        fault = 3'h0;
        hw_reset();
        // Defaults; port count follows the enable live
        rdchk(OFF_DESC_A, 32'h01000002, "desc a default");
        rdchk(OFF_DESC_B, 32'h00000000, "desc b default");
        third_port_en <= 1'b1;
        rdchk(OFF_DESC_A, 32'h01000003, "three ports");
        // All-ones writes: only stored bits come back
        wr(OFF_DESC_A, 32'hffffffff);
        rdchk(OFF_DESC_A, 32'h03001b03, "desc a bits");
        wr(OFF_DESC_B, 32'hffffffff);
        rdchk(OFF_DESC_B, 32'h000e0000, "desc b bits");
        $display("test defaults done");
        // Hub-state reset keeps descriptors; only hardware reset clears them
        usb_state_reset <= 1'b1;
        repeat (4) @(posedge pclk);
        usb_state_reset <= 1'b0;
        rdchk(OFF_DESC_A, 32'h03001b03, "usb reset a");
        rdchk(OFF_DESC_B, 32'h000e0000, "usb reset b");
        hw_reset();
        rdchk(OFF_DESC_A, 32'h01000003, "hw reset a");
        rdchk(OFF_DESC_B, 32'h00000000, "hw reset b");
        $display("test reset done");
        // Global scope: zero write and per-port command do nothing
        wr(OFF_DESC_A, 32'h02000000);
        wr(OFF_RH_STATUS, 32'h00000000);
        wr(OFF_PORT_CMD, 32'h00000002);
        rdchk(OFF_PORT_CMD, 32'h00000000, "no stray power");
        wr(OFF_RH_STATUS, 32'h00010000);
        rdchk(OFF_PORT_CMD, 32'h0000000e, "global on");
        chk({29'h0, port_power}, 32'h00000007, "global on pins");
        // Code 2 must still be settling where code 1 would be done
        repeat (UNIT + 4) @(posedge pclk);
        chk({31'h0, power_good}, 32'h0, "settling");
        repeat (UNIT) @(posedge pclk);
        chk({31'h0, power_good}, 32'h1, "settled");
        $display("test settle done");
        // Fault on port 1 reported, then hidden by the disable bit
        fault <= 3'b001;
        repeat (3) @(posedge pclk);
        chk({31'h0, overcurrent_alert}, 32'h1, "oc alert");
        rdchk(OFF_RH_STATUS, 32'h00000002, "oc status");
        wr(OFF_DESC_A, 32'h02001800);
        rdchk(OFF_RH_STATUS, 32'h00000000, "oc hidden");
        fault <= 3'b000;
        wr(OFF_RH_STATUS, 32'h00000001);
        rdchk(OFF_PORT_CMD, 32'h00000000, "global off");
        $display("test overcurrent done");
        // Per-port scope: port 2 masked to per-port commands
        wr(OFF_DESC_A, 32'h01000100);
        wr(OFF_DESC_B, 32'h00040000);
        wr(OFF_RH_STATUS, 32'h00010000);
        rdchk(OFF_PORT_CMD, 32'h0000000a, "global skips masked");
        wr(OFF_PORT_CMD, 32'h00000004);
        rdchk(OFF_PORT_CMD, 32'h0000000e, "per-port on");
        wr(OFF_RH_STATUS, 32'h00000001);
        rdchk(OFF_PORT_CMD, 32'h00000004, "masked stays");
        // Hub-state reset drops switched power but keeps the mask
        usb_state_reset <= 1'b1;
        rdchk(OFF_PORT_CMD, 32'h00000000, "hub reset off");
        usb_state_reset <= 1'b0;
        rdchk(OFF_DESC_B, 32'h00040000, "mask kept");
        $display("test per-port done");
        // Always powered ignores hub reset; port 3 absent without enable
        wr(OFF_DESC_A, 32'h01000200);
        usb_state_reset <= 1'b1;
        third_port_en <= 1'b0;
        rdchk(OFF_PORT_CMD, 32'h00000006, "always on");
        rdchk(OFF_DESC_A, 32'h01000202, "two ports");
        usb_state_reset <= 1'b0;
        // Unmapped word refuses and reads zero
        xfer(1'b1, 12'h044, 32'hffffffff);
        chk({31'h0, er}, 32'h1, "unmapped err");
        xfer(1'b0, 12'h044, 32'h0);
        chk(rd, 32'h0, "unmapped data");
        $display("test misc done");
        finish_test();
    end
endmodule
